// ===== hdl/rssa_defines.vh
// Shared constants of the rotate/shift/subtract datapath: opcodes, flag positions,
// register offsets, reset values and instruction timing.
// Assumes inclusion by bare name from every design file of the block.
`ifndef RSSA_DEFINES_VH
`define RSSA_DEFINES_VH

// Opcodes
`define RSSA_OP_RRC_R 8'hc0
`define RSSA_OP_RRC_IR 8'hc1
`define RSSA_OP_SRA_R 8'hd0
`define RSSA_OP_SRA_IR 8'hd1
`define RSSA_OP_SCF 8'hdf
`define RSSA_OP_STOP 8'h7f
`define RSSA_OP_SUB_FIRST 8'h22
`define RSSA_OP_SUB_LAST 8'h26
`define RSSA_OP_SBC_FIRST 8'h32
`define RSSA_OP_SBC_LAST 8'h36

// Datapath operation classes
`define RSSA_ALU_NONE 3'h0
`define RSSA_ALU_SUB 3'h1
`define RSSA_ALU_SBC 3'h2
`define RSSA_ALU_RRC 3'h3
`define RSSA_ALU_SRA 3'h4
`define RSSA_ALU_SCF 3'h5

// Flag bit positions
`define RSSA_FLAG_C 7
`define RSSA_FLAG_Z 6
`define RSSA_FLAG_S 5
`define RSSA_FLAG_V 4
`define RSSA_FLAG_D 3
`define RSSA_FLAG_H 2
`define RSSA_FLAGS_MASK 8'hfc
`define RSSA_FLAGS_RST 8'h00

// Register offsets
`define RSSA_ADDR_FLAGS 4'h0
`define RSSA_ADDR_STATUS 4'h4
`define RSSA_ADDR_RESULT 4'h8
`define RSSA_ADDR_OPCODE 4'hc

// Instruction sizes and cycle counts
`define RSSA_BYTES_1 2'h1
`define RSSA_BYTES_2 2'h2
`define RSSA_BYTES_3 2'h3
`define RSSA_CYC_SHORT 4'h4
`define RSSA_CYC_LONG 4'h6

`endif

// ===== hdl/rssa_arith.v
// Combinational result and flag unit for subtract, rotate, shift and set-carry.
// Assumes the caller holds operands and flags stable while it samples the outputs.
`timescale 1ns/1ps
`include "rssa_defines.vh"

module rssa_arith (
  // Operation and operands
  input wire [2:0] aluOp,
  input wire [7:0] dstVal,
  input wire [7:0] srcVal,
  input wire [7:0] flagsIn,
  // Results
  output reg [7:0] resultVal,
  output reg [7:0] flagsOut,
  output reg dstWrite
);

  wire subCin;
  wire [8:0] diffSum;
  wire [4:0] lowSum;

  // Two's complement add; the borrow enters as an inverted carry
  assign subCin = (aluOp == `RSSA_ALU_SBC) ? ~flagsIn[`RSSA_FLAG_C] : 1'b1;
  assign diffSum = {1'b0, dstVal} + {1'b0, ~srcVal} + {8'h00, subCin};
  assign lowSum = {1'b0, dstVal[3:0]} + {1'b0, ~srcVal[3:0]} + {4'h0, subCin};

  always @* begin
    resultVal = dstVal;
    flagsOut = flagsIn;
    dstWrite = 1'b0;
    case (aluOp)
      `RSSA_ALU_SUB, `RSSA_ALU_SBC: begin
        resultVal = diffSum[7:0];
        dstWrite = 1'b1;
        flagsOut[`RSSA_FLAG_C] = ~diffSum[8];
        flagsOut[`RSSA_FLAG_Z] = (diffSum[7:0] == 8'h00);
        flagsOut[`RSSA_FLAG_S] = diffSum[7];
        flagsOut[`RSSA_FLAG_V] = (dstVal[7] != srcVal[7]) && (diffSum[7] == srcVal[7]);
        flagsOut[`RSSA_FLAG_D] = 1'b1;
        flagsOut[`RSSA_FLAG_H] = ~lowSum[4];
      end
      `RSSA_ALU_RRC: begin
        resultVal = {flagsIn[`RSSA_FLAG_C], dstVal[7:1]};
        dstWrite = 1'b1;
        flagsOut[`RSSA_FLAG_C] = dstVal[0];
        flagsOut[`RSSA_FLAG_Z] = ({flagsIn[`RSSA_FLAG_C], dstVal[7:1]} == 8'h00);
        flagsOut[`RSSA_FLAG_S] = flagsIn[`RSSA_FLAG_C];
        flagsOut[`RSSA_FLAG_V] = dstVal[7] ^ flagsIn[`RSSA_FLAG_C];
      end
      `RSSA_ALU_SRA: begin
        resultVal = {dstVal[7], dstVal[7:1]};
        dstWrite = 1'b1;
        flagsOut[`RSSA_FLAG_C] = dstVal[0];
        flagsOut[`RSSA_FLAG_Z] = (dstVal[7:1] == 7'h00);
        flagsOut[`RSSA_FLAG_S] = dstVal[7];
        flagsOut[`RSSA_FLAG_V] = 1'b0;
      end
      `RSSA_ALU_SCF: begin
        flagsOut[`RSSA_FLAG_C] = 1'b1;
      end
      default: begin
        resultVal = dstVal;
      end
    endcase
  end

endmodule // rssa_arith

// ===== hdl/rssa_decode.v
// Opcode decoder: operation class, size, cycle count and operand fields.
// Assumes byte1 and byte2 are the instruction bytes that follow the opcode.
`timescale 1ns/1ps
`include "rssa_defines.vh"

module rssa_decode (
  // Instruction bytes
  input wire [7:0] opcode,
  input wire [7:0] byte1,
  input wire [7:0] byte2,
  // Decoded attributes
  output reg legal,
  output reg stopOp,
  output reg [2:0] aluOp,
  output reg [1:0] numBytes,
  output reg [3:0] numCycles,
  // Decoded operand fields
  output reg [7:0] dstAddr,
  output reg [7:0] srcAddr,
  output reg dstIndirect,
  output reg srcIndirect,
  output reg srcImm,
  output reg workForm
);

  wire isSub;
  wire isSbc;

  assign isSub = (opcode >= `RSSA_OP_SUB_FIRST) && (opcode <= `RSSA_OP_SUB_LAST);
  assign isSbc = (opcode >= `RSSA_OP_SBC_FIRST) && (opcode <= `RSSA_OP_SBC_LAST);

  always @* begin
    legal = 1'b1;
    stopOp = 1'b0;
    aluOp = `RSSA_ALU_NONE;
    numBytes = `RSSA_BYTES_1;
    numCycles = `RSSA_CYC_SHORT;
    dstAddr = 8'h00;
    srcAddr = 8'h00;
    dstIndirect = 1'b0;
    srcIndirect = 1'b0;
    srcImm = 1'b0;
    workForm = 1'b0;
    if (isSub || isSbc) begin
      aluOp = isSbc ? `RSSA_ALU_SBC : `RSSA_ALU_SUB;
      case (opcode[3:0])
        4'h2, 4'h3: begin
          numBytes = `RSSA_BYTES_2;
          numCycles = opcode[0] ? `RSSA_CYC_LONG : `RSSA_CYC_SHORT;
          workForm = 1'b1;
          dstAddr = {4'h0, byte1[7:4]};
          srcAddr = {4'h0, byte1[3:0]};
          srcIndirect = opcode[0];
        end
        4'h4, 4'h5: begin
          numBytes = `RSSA_BYTES_3;
          numCycles = `RSSA_CYC_LONG;
          srcAddr = byte1;
          dstAddr = byte2;
          srcIndirect = opcode[0];
        end
        default: begin
          numBytes = `RSSA_BYTES_3;
          numCycles = `RSSA_CYC_LONG;
          dstAddr = byte1;
          srcAddr = byte2;
          srcImm = 1'b1;
        end
      endcase
    end else begin
      case (opcode)
        `RSSA_OP_RRC_R, `RSSA_OP_RRC_IR, `RSSA_OP_SRA_R, `RSSA_OP_SRA_IR: begin
          aluOp = opcode[4] ? `RSSA_ALU_SRA : `RSSA_ALU_RRC;
          numBytes = `RSSA_BYTES_2;
          numCycles = `RSSA_CYC_SHORT;
          dstAddr = byte1;
          dstIndirect = opcode[0];
        end
        `RSSA_OP_SCF: begin
          aluOp = `RSSA_ALU_SCF;
        end
        `RSSA_OP_STOP: begin
          stopOp = 1'b1;
        end
        default: begin
          legal = 1'b0;
        end
      endcase
    end
  end

endmodule // rssa_decode

// ===== hdl/rssa_core.v
// Execution core: accepts one instruction at a time, times it, commits result
// and flags, manages stop mode, and exposes flags and status on a register port.
// Assumes the fetch logic delivers operand values together with the instruction
// and performs the write-back that the wb outputs describe.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "rssa_defines.vh"

// Overview of operation
// - Rotate right through carry, C0/C1, 4 cycles
// - Rotate flags: Z, S, V sign change
// - Borrow subtract: dst minus src minus carry
// - Borrow subtract chains previous borrow
// - Borrow subtract sets C, Z, S
// - Borrow subtract overflow from operand signs
// - Subtracts set D, H is half borrow
// - Set carry DF, other flags kept
// - Signed shift right D0/D1, 4 cycles
// - Shift flags: C, Z, S, V cleared
// - Stop opcode 7F halts both clocks
// - Stop mode keeps all register contents; a register-port write still changes the flags
// - Stop ends on reset or interrupt
// - Plain subtract dst minus src, 22-26
// - Plain subtract overflow from operand signs
// - Plain subtract carry marks borrow
module rssa_core (
  // Clock and reset
  input wire core_clk,
  input wire arst_n,
  // Instruction issue
  input wire instrValid,
  input wire [7:0] instrOpcode,
  input wire [7:0] instrByte1,
  input wire [7:0] instrByte2,
  input wire [7:0] dstValue,
  input wire [7:0] srcValue,
  output wire instrReady,
  // Completion and write-back
  output reg execDone_reg,
  output reg illegalOp_reg,
  output reg wbWrite_reg,
  output reg [7:0] wbData_reg,
  output reg [7:0] wbAddr_reg,
  output reg wbIndirect_reg,
  output reg wbWork_reg,
  // Decoded instruction attributes
  output reg [7:0] srcAddr_reg,
  output reg srcIndirect_reg,
  output reg srcImm_reg,
  output reg [1:0] instrBytes_reg,
  output reg [3:0] instrCycles_reg,
  // Flags and clock control
  output reg [7:0] flags_reg,
  output wire stopMode,
  output wire cpuClkEn,
  output wire sysClkEn,
  input wire extIrq,
  // Register port
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata_reg
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_STOP = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [3:0] cnt_reg;
  reg [2:0] aluOp_reg;
  reg stopOp_reg;
  reg [7:0] dstVal_reg;
  reg [7:0] srcVal_reg;
  reg [7:0] opcode_reg;

  wire decLegal;
  wire decStop;
  wire [2:0] decAluOp;
  wire [1:0] decBytes;
  wire [3:0] decCycles;
  wire [7:0] decDstAddr;
  wire [7:0] decSrcAddr;
  wire decDstInd;
  wire decSrcInd;
  wire decSrcImm;
  wire decWork;
  wire [7:0] aluResult;
  wire [7:0] aluFlags;
  wire aluWrite;
  wire accept;
  wire commit;
  wire [7:0] statusWord;
  reg [7:0] readMux;

  rssa_decode u_decode (
    .opcode(instrOpcode),
    .byte1(instrByte1),
    .byte2(instrByte2),
    .legal(decLegal),
    .stopOp(decStop),
    .aluOp(decAluOp),
    .numBytes(decBytes),
    .numCycles(decCycles),
    .dstAddr(decDstAddr),
    .srcAddr(decSrcAddr),
    .dstIndirect(decDstInd),
    .srcIndirect(decSrcInd),
    .srcImm(decSrcImm),
    .workForm(decWork)
  );

  // Computed at commit from the latched operands and the live flags
  rssa_arith u_arith (
    .aluOp(aluOp_reg),
    .dstVal(dstVal_reg),
    .srcVal(srcVal_reg),
    .flagsIn(flags_reg),
    .resultVal(aluResult),
    .flagsOut(aluFlags),
    .dstWrite(aluWrite)
  );

  assign instrReady = (state_reg == ST_IDLE);
  assign accept = instrValid && instrReady && decLegal;
  assign commit = (state_reg == ST_EXEC) && (cnt_reg == 4'h0);
  assign stopMode = (state_reg == ST_STOP);
  assign cpuClkEn = ~stopMode;
  assign sysClkEn = ~stopMode;
  assign statusWord = {6'h00, (state_reg == ST_EXEC), stopMode};

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (commit) begin
          state_next = stopOp_reg ? ST_STOP : ST_IDLE;
        end
      end
      ST_STOP: begin
        // Only an interrupt leaves here; reset returns to idle directly
        if (extIrq) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer; in stop mode only state_reg changes, on an interrupt, so all other state is retained
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      aluOp_reg <= `RSSA_ALU_NONE;
      stopOp_reg <= 1'b0;
      dstVal_reg <= 8'h00;
      srcVal_reg <= 8'h00;
      opcode_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        cnt_reg <= decCycles - 4'h1;
        aluOp_reg <= decAluOp;
        stopOp_reg <= decStop;
        dstVal_reg <= dstValue;
        srcVal_reg <= srcValue;
        opcode_reg <= instrOpcode;
      end else if ((state_reg == ST_EXEC) && (cnt_reg != 4'h0)) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end

  // Decoded attributes, held from acceptance until the next one
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wbAddr_reg <= 8'h00;
      wbIndirect_reg <= 1'b0;
      wbWork_reg <= 1'b0;
      srcAddr_reg <= 8'h00;
      srcIndirect_reg <= 1'b0;
      srcImm_reg <= 1'b0;
      instrBytes_reg <= 2'h0;
      instrCycles_reg <= 4'h0;
    end else if (accept) begin
      wbAddr_reg <= decDstAddr;
      wbIndirect_reg <= decDstInd;
      wbWork_reg <= decWork;
      srcAddr_reg <= decSrcAddr;
      srcIndirect_reg <= decSrcInd;
      srcImm_reg <= decSrcImm;
      instrBytes_reg <= decBytes;
      instrCycles_reg <= decCycles;
    end
  end

  // Completion strobes and result
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      execDone_reg <= 1'b0;
      illegalOp_reg <= 1'b0;
      wbWrite_reg <= 1'b0;
      wbData_reg <= 8'h00;
    end else begin
      execDone_reg <= commit;
      illegalOp_reg <= instrValid && instrReady && !decLegal;
      wbWrite_reg <= commit && aluWrite;
      if (commit && aluWrite) begin
        wbData_reg <= aluResult;
      end
    end
  end

  // Flags: a commit wins over a software write in the same cycle
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_reg <= `RSSA_FLAGS_RST;
    end else if (commit) begin
      flags_reg <= aluFlags;
    end else if (regWrite && (regAddr == `RSSA_ADDR_FLAGS)) begin
      flags_reg <= regWdata & `RSSA_FLAGS_MASK;
    end
  end

  always @* begin
    case (regAddr)
      `RSSA_ADDR_FLAGS: readMux = flags_reg;
      `RSSA_ADDR_STATUS: readMux = statusWord;
      `RSSA_ADDR_RESULT: readMux = wbData_reg;
      `RSSA_ADDR_OPCODE: readMux = opcode_reg;
      default: readMux = 8'h00;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata_reg <= 8'h00;
    end else begin
      regRdata_reg <= regRead ? readMux : 8'h00;
    end
  end

endmodule // rssa_core

// ===== verification/rssa_core_chk.sv
// Concurrent checks on the execution core's ports.
// Assumes it is bound into rssa_core and sees only its ports.
`timescale 1ns/1ps
module rssa_core_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Instruction issue and completion
  input wire logic instrValid,
  input wire logic [7:0] instrOpcode,
  input wire logic instrReady,
  input wire logic execDone_reg,
  input wire logic wbWrite_reg,
  // Flags, stop and register port
  input wire logic [7:0] flags_reg,
  input wire logic stopMode,
  input wire logic cpuClkEn,
  input wire logic sysClkEn,
  input wire logic extIrq,
  input wire logic regWrite
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire take = instrValid && instrReady;
  wire [3:0] lo = instrOpcode[3:0];
  wire subOp = instrOpcode[7:4] == 4'h2 || instrOpcode[7:4] == 4'h3;
  wire shortOp = instrOpcode inside {8'h22, 8'h32, 8'hc0, 8'hc1, 8'hd0, 8'hd1, 8'hdf, 8'h7f};
  wire longOp = subOp && lo >= 4'h3 && lo <= 4'h6;
  sequence s_short; take && shortOp; endsequence
  sequence s_long; take && longOp; endsequence
  property p_done4; s_short |-> ##5 execDone_reg; endproperty
  a_done4: assert property (p_done4) else $error("short op done late");
  property p_done6; s_long |-> ##7 execDone_reg; endproperty
  a_done6: assert property (p_done6) else $error("long op done late");
  property p_stopIn;
    (s_short and (instrOpcode == 8'h7f)) |-> ##5 (stopMode && !wbWrite_reg);
  endproperty
  a_stopIn: assert property (p_stopIn) else $error("stop not entered");
  property p_setC;
    (s_short and (instrOpcode == 8'hdf)) |-> ##5 (flags_reg[7] && !wbWrite_reg);
  endproperty
  a_setC: assert property (p_setC) else $error("carry not set");
  property p_subD; (s_short and subOp) |-> ##5 (flags_reg[3] && wbWrite_reg); endproperty
  a_subD: assert property (p_subD) else $error("subtract marker clear");
  property p_clkEn; cpuClkEn == !stopMode && sysClkEn == !stopMode; endproperty
  a_clkEn: assert property (p_clkEn) else $error("clock enable wrong");
  property p_stay; stopMode && !extIrq |=> stopMode; endproperty
  a_stay: assert property (p_stay) else $error("stop left without cause");
  property p_leave; stopMode && extIrq |=> !stopMode; endproperty
  a_leave: assert property (p_leave) else $error("stop not left");
  property p_keep; stopMode && !regWrite |=> $stable(flags_reg); endproperty
  a_keep: assert property (p_keep) else $error("flags changed in stop");
  property p_noIssue; stopMode |-> !instrReady; endproperty
  a_noIssue: assert property (p_noIssue) else $error("ready in stop");
endmodule // rssa_core_chk

bind rssa_core rssa_core_chk chk (.core_clk, .arst_n, .instrValid, .instrOpcode, .instrReady,
  .execDone_reg, .wbWrite_reg, .flags_reg, .stopMode, .cpuClkEn, .sysClkEn, .extIrq, .regWrite);

// ===== verification/rssa_tb_top.sv
// Self-checking bench for the execution core: instruction and register tasks.
// Assumes the core and its checker are compiled before this file.
`timescale 1ns/1ps
module rssa_tb_top;
  reg core_clk = 1'b0;
  reg arst_n = 1'b0;
  reg instrValid = 1'b0;
  reg extIrq = 1'b0;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  reg [3:0] regAddr = 4'h0;
  reg [7:0] instrOpcode = 8'h00;
  reg [7:0] instrByte1 = 8'h00;
  reg [7:0] instrByte2 = 8'h00;
  reg [7:0] dstValue = 8'h00;
  reg [7:0] srcValue = 8'h00;
  reg [7:0] regWdata = 8'h00;
  wire instrReady;
  wire execDone_reg;
  wire wbWrite_reg;
  wire stopMode;
  wire cpuClkEn;
  wire sysClkEn;
  wire [1:0] instrBytes_reg;
  wire [3:0] instrCycles_reg;
  wire [7:0] wbData_reg;
  wire [7:0] wbAddr_reg;
  wire [7:0] srcAddr_reg;
  wire [7:0] flags_reg;
  wire [7:0] regRdata_reg;
  wire illegalOp_reg;
  wire wbIndirect_reg;
  wire wbWork_reg;
  wire srcIndirect_reg;
  wire srcImm_reg;
  integer n_errors = 0;
  integer compares = 0;
  integer i;
  reg [7:0] mf, er, v, k, j, op, d, s;
  always #2 core_clk = ~core_clk;
  rssa_core dut (.core_clk, .arst_n, .instrValid, .instrOpcode, .instrByte1, .instrByte2,
    .dstValue, .srcValue, .instrReady, .execDone_reg, .illegalOp_reg, .wbWrite_reg,
    .wbData_reg, .wbAddr_reg, .wbIndirect_reg, .wbWork_reg, .srcAddr_reg,
    .srcIndirect_reg, .srcImm_reg, .instrBytes_reg, .instrCycles_reg, .flags_reg,
    .stopMode, .cpuClkEn, .sysClkEn, .extIrq, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata_reg);
  // Expected {result, flags}
  function [15:0] model(input [7:0] o, input [7:0] a, input [7:0] b, input [7:0] f);
    reg [8:0] t;
    reg [7:0] r;
    reg c;
    begin
      model = {a, f};
      if (o[7:4] == 4'h2 || o[7:4] == 4'h3) begin
        c = o[4] & f[7];
        t = {1'b0, a} - {1'b0, b} - c;
        r = t[7:0];
        model = {r, t[8], r == 8'h00, r[7], a[7] != b[7] && r[7] == b[7], 1'b1,
          {1'b0, a[3:0]} < {1'b0, b[3:0]} + c, 2'b00};
      end else if (o[7:1] == 7'h60) begin
        r = {f[7], a[7:1]};
        model = {r, a[0], r == 8'h00, r[7], r[7] != a[7], f[3:2], 2'b00};
      end else if (o[7:1] == 7'h68) begin
        r = {a[7], a[7:1]};
        model = {r, a[0], r == 8'h00, r[7], 1'b0, f[3:2], 2'b00};
      end else if (o == 8'hdf)
        model = {a, f | 8'h80};
    end
  endfunction
  task chk(input [8*8-1:0] nm, input [7:0] e, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task chk1(input [8*8-1:0] nm, input e, input g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s exp %b got %b", nm, e, g);
      end
    end
  endtask
  task test_done;
    begin
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task wr(input [3:0] a, input [7:0] w);
    begin
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= w;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [7:0] r);
    begin
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 r = regRdata_reg;
    end
  endtask
  task exec(input [7:0] o, input [7:0] b1, input [7:0] b2, input [7:0] a, input [7:0] b);
    begin
      @(posedge core_clk);
      instrOpcode <= o;
      instrByte1 <= b1;
      instrByte2 <= b2;
      dstValue <= a;
      srcValue <= b;
      instrValid <= 1'b1;
      @(posedge core_clk);
      instrValid <= 1'b0;
      #1;
      for (i = 0; i < 20 && execDone_reg !== 1'b1; i = i + 1)
        @(posedge core_clk) #1;
      if (execDone_reg !== 1'b1) begin
        n_errors = n_errors + 1;
        $display("[FAIL] done exp 1 got %b", execDone_reg);
        test_done;
      end
      {er, mf} = model(o, a, b, mf);
      chk1("wbWrite", o != 8'hdf && o != 8'h7f, wbWrite_reg);
      if (o != 8'hdf && o != 8'h7f)
        chk("result", er, wbData_reg);
      chk("flags", mf, flags_reg);
    end
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    #1 chk1("clkEn", 1'b1, cpuClkEn);
    wr(4'h0, 8'hff);
    mf = 8'hfc;
    rd(4'h0, v);
    chk("flagsRd", mf, v);
    rd(4'h2, v);
    chk("unmapped", 8'h00, v);
    // All subtract forms, with no borrow pending for the first borrowing one
    for (k = 8'h00; k < 8'h0a; k = k + 8'h01) begin
      j = (k > 8'h04) ? k - 8'h05 : k;
      op = 8'h22 + j + ((k > 8'h04) ? 8'h10 : 8'h00);
      d = 8'h21 ^ (k * 8'h37);
      s = 8'h90 + k * 8'h13;
      exec(op, 8'h40 + k, s, d, s);
      chk("bytes", (j < 8'h02) ? 8'h02 : 8'h03, {6'h00, instrBytes_reg});
      chk("cycles", (j == 8'h00) ? 8'h04 : 8'h06, {4'h0, instrCycles_reg});
      if (j > 8'h01)
        chk("dstAddr", (j == 8'h04) ? 8'h40 + k : s, wbAddr_reg);
      if (j == 8'h02 || j == 8'h03)
        chk("srcAddr", 8'h40 + k, srcAddr_reg);
      if (j < 8'h02) begin
        chk("dstAddr", 8'h04, wbAddr_reg);
        chk("srcAddr", {4'h0, k[3:0]}, srcAddr_reg);
      end
      chk1("work", j < 8'h02, wbWork_reg);
      chk1("srcInd", j == 8'h01 || j == 8'h03, srcIndirect_reg);
      chk1("srcImm", j == 8'h04, srcImm_reg);
    end
    exec(8'h22, 8'h12, 8'h00, 8'h00, 8'h01);
    exec(8'h32, 8'h12, 8'h00, 8'h12, 8'h03);
    chk("chain", 8'h0e, wbData_reg);
    rd(4'h8, v);
    chk("resultRd", 8'h0e, v);
    wr(4'h8, 8'h55);
    rd(4'h8, v);
    chk("roWrite", 8'h0e, v);
    rd(4'hc, v);
    chk("opRd", 8'h32, v);
    @(posedge core_clk);
    instrOpcode <= 8'h27;
    instrValid <= 1'b1;
    @(posedge core_clk);
    instrValid <= 1'b0;
    #1 chk1("illegal", 1'b1, illegalOp_reg);
    chk1("ready", 1'b1, instrReady);
    chk("flags", mf, flags_reg);
    exec(8'hdf, 8'h00, 8'h00, 8'h00, 8'h00);
    chk("bytes", 8'h01, {6'h00, instrBytes_reg});
    chk("cycles", 8'h04, {4'h0, instrCycles_reg});
    exec(8'hdf, 8'h00, 8'h00, 8'h00, 8'h00);
    rd(4'h0, v);
    chk("flagsRd", mf, v);
    for (k = 8'h00; k < 8'h04; k = k + 8'h01) begin
      case (k)
        8'h00: d = 8'h55;
        8'h01: d = 8'h81;
        8'h02: d = 8'h9a;
        default: d = 8'h01;
      endcase
      exec((k[1] ? 8'hd0 : 8'hc0) | {7'h00, k[0]}, 8'h05, 8'h00, d, 8'h00);
      chk("dstAddr", 8'h05, wbAddr_reg);
      chk1("dstInd", k[0], wbIndirect_reg);
      chk("cycles", 8'h04, {4'h0, instrCycles_reg});
    end
    exec(8'h7f, 8'h00, 8'h00, 8'h00, 8'h00);
    chk1("stop", 1'b1, stopMode);
    chk1("sysEn", 1'b0, sysClkEn);
    rd(4'h4, v);
    chk("status", 8'h01, v);
    @(posedge core_clk);
    instrOpcode <= 8'h22;
    instrValid <= 1'b1;
    repeat (3) @(posedge core_clk);
    instrValid <= 1'b0;
    extIrq <= 1'b1;
    #1 chk1("stop", 1'b1, stopMode);
    chk("flags", mf, flags_reg);
    chk1("ready", 1'b0, instrReady);
    @(posedge core_clk);
    extIrq <= 1'b0;
    #1 chk1("stop", 1'b0, stopMode);
    rd(4'hc, v);
    chk("opRd", 8'h7f, v);
    exec(8'h7f, 8'h00, 8'h00, 8'h00, 8'h00);
    @(posedge core_clk);
    arst_n <= 1'b0;
    @(posedge core_clk);
    arst_n <= 1'b1;
    #1 chk1("stop", 1'b0, stopMode);
    chk1("ready", 1'b1, instrReady);
    mf = 8'h00;
    chk("flags", mf, flags_reg);
    exec(8'hdf, 8'h00, 8'h00, 8'h00, 8'h00);
    test_done;
  end
endmodule // rssa_tb_top
